// >>> hdl/cwfc_top.sv
// Control word side-band handling: flow calendar pack and unpack,
// multi-use field insert and extract, resend sequence numbering.
// Assumes the framer strobes each control word in and out one per cycle,
// and an AHB-Lite master that only makes single word transfers.
//
// Behaviour
// - Resend off: latest word bits 31:24 out
// - Resend on: latest burst word sequence out
// - Channel extension zeroes top multi-use bits
// - One-cycle pulse when multi-use output updates
// - Flow bits 55:40, restart flag 56
// - Calendar one means on, zero off
// - Transmit entry 0 at bit 55, restart
// - Length codes select 16 to 256 entries
// - Receive unpacks calendar with same mapping
// - CRC24 error triggers resend of bursts
// - Resend request on agreed out-of-band bit
// - Sequence number repeated per multiplier bursts
// - Multipliers 1, 2, 4, 8, 16, 32
// - Transmit multi-use input into bits 31:24
//
// Chosen here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
module cwfc_top (
    input  wire logic                 ref_clk_in,
    input  wire logic                 rst_n_in,
    // AHB-Lite slave
    input  wire logic                 hsel_in,
    input  wire logic [7:0]           haddr_in,
    input  wire logic [1:0]           htrans_in,
    input  wire logic                 hwrite_in,
    input  wire logic [2:0]           hsize_in,
    input  wire logic [31:0]          hwdata_in,
    input  wire logic                 hready_in,
    output logic [31:0]               hrdata_out,
    output logic                      hreadyout_out,
    output logic                      hresp_out,
    // Transmit control word side-band
    input  wire logic                 tx_cw_req_in,
    input  wire logic                 tx_cw_burst_in,
    input  wire logic [255:0]         tx_flow_calendar_in,
    output logic                      tx_cw_valid_out,
    output cwfc_pkg::cwfc_side_t      tx_cw_fields_out,
    // Receive control word side-band
    input  wire logic                 rx_cw_valid_in,
    input  wire logic                 rx_cw_burst_in,
    input  wire logic                 rx_crc24_error_in,
    input  wire cwfc_pkg::cwfc_side_t rx_cw_fields_in,
    output logic [7:0]                rx_multiuse_out,
    output logic                      rx_multiuse_updated_out,
    output logic [255:0]              rx_flow_calendar_out,
    // Resend control towards the out-of-band flow path and receiver
    output logic                      oob_resend_req_out,
    output logic [7:0]                oob_resend_pos_out,
    output logic                      rx_packet_interleave_sel_out
);

    // ========================================================================
    // Helper functions
    function automatic logic [7:0] mu_mask(input logic [1:0] ext);
        mu_mask = cwfc_pkg::MU_FULL_MASK >> ext;
    endfunction

    // Valid length codes equal the last group index; reserved codes fall
    // back to the shortest calendar so a bad value never reads stale entries
    function automatic logic [3:0] last_group(input logic [3:0] code);
        case (code)
            cwfc_pkg::CALLEN_16,
            cwfc_pkg::CALLEN_32,
            cwfc_pkg::CALLEN_64,
            cwfc_pkg::CALLEN_128,
            cwfc_pkg::CALLEN_256: last_group = code;
            default:              last_group = cwfc_pkg::CALLEN_16;
        endcase
    endfunction

    // ========================================================================
    // Register bus state
    logic [31:0] ctrl_reg,    ctrl_next;
    logic [7:0]  tx_mu_reg,   tx_mu_next;
    logic [3:0]  cal_sel_reg, cal_sel_next;
    logic        wr_pend_reg, wr_pend_next;
    logic [7:0]  wr_addr_reg, wr_addr_next;
    logic [31:0] rdata_reg,   rdata_next;

    logic        rx_resend_on;
    logic        tx_resend_on;
    logic [1:0]  rx_channel_extension_sel;
    logic [1:0]  tx_channel_extension_sel;
    logic [3:0]  tx_calendar_length_sel;
    logic [2:0]  mult_code;
    logic [3:0]  cal_last;
    logic [4:0]  mult_last;

    logic [15:0] rx_group_word;
    logic        rx_cal_locked;

    // ========================================================================
    // Data path state
    logic [3:0]  tx_group_reg, tx_group_next;
    logic [7:0]  tx_seq_reg,   tx_seq_next;
    logic [4:0]  tx_sub_reg,   tx_sub_next;
    logic        tx_vld_reg,   tx_vld_next;
    cwfc_pkg::cwfc_side_t tx_fld_reg, tx_fld_next;
    logic [7:0]  rx_mu_reg,    rx_mu_next;
    logic        rx_upd_reg,   rx_upd_next;
    logic        oob_req_reg,  oob_req_next;

    // Control field split
    assign rx_resend_on             = ctrl_reg[cwfc_pkg::CTRL_RX_RESEND];
    assign tx_resend_on             = ctrl_reg[cwfc_pkg::CTRL_TX_RESEND];
    assign rx_channel_extension_sel = ctrl_reg[cwfc_pkg::CTRL_RX_EXT_LO +: 2];
    assign tx_channel_extension_sel = ctrl_reg[cwfc_pkg::CTRL_TX_EXT_LO +: 2];
    assign tx_calendar_length_sel   = ctrl_reg[cwfc_pkg::CTRL_CALLEN_LO +: 4];
    assign mult_code                = ctrl_reg[cwfc_pkg::CTRL_MULT_LO +: 3];
    assign cal_last                 = last_group(tx_calendar_length_sel);

    // Unsupported multiplier codes run as times one
    assign mult_last = (mult_code > cwfc_pkg::MULT_CODE_MAX) ? 5'h00 :
                       5'((6'h01 << mult_code) - 6'h01);

    // ========================================================================
    // AHB-Lite slave: zero wait states, always OKAY, unmapped reads zero
    always_comb begin
        logic addr_ok;
        addr_ok      = hsel_in && htrans_in[1] && hready_in;
        ctrl_next    = ctrl_reg;
        tx_mu_next   = tx_mu_reg;
        cal_sel_next = cal_sel_reg;
        rdata_next   = rdata_reg;
        wr_pend_next = addr_ok && hwrite_in;
        wr_addr_next = addr_ok ? haddr_in : wr_addr_reg;
        // Data phase of an earlier write lands now
        if (wr_pend_reg) begin
            case (wr_addr_reg)
                cwfc_pkg::ADDR_CTRL:    ctrl_next    = hwdata_in;
                cwfc_pkg::ADDR_TX_MU:   tx_mu_next   = hwdata_in[7:0];
                cwfc_pkg::ADDR_CAL_SEL: cal_sel_next = hwdata_in[3:0];
                default:                ctrl_next    = ctrl_reg;
            endcase
        end
        // Read data sampled in the address phase, shown in the data phase
        if (addr_ok && !hwrite_in) begin
            case (haddr_in)
                cwfc_pkg::ADDR_CTRL:     rdata_next = ctrl_reg;
                cwfc_pkg::ADDR_TX_MU:    rdata_next = {24'h000000, tx_mu_reg};
                cwfc_pkg::ADDR_STATUS:   rdata_next = {14'h0000, rx_cal_locked,
                                                       oob_req_reg, tx_seq_reg,
                                                       rx_mu_reg};
                cwfc_pkg::ADDR_CAL_SEL:  rdata_next = {28'h0000000, cal_sel_reg};
                cwfc_pkg::ADDR_CAL_WORD: rdata_next = {16'h0000, rx_group_word};
                default:                 rdata_next = 32'h0000_0000;
            endcase
        end
    end

    // Bus registers
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_reg    <= cwfc_pkg::CTRL_RESET;
            tx_mu_reg   <= cwfc_pkg::TX_MU_RESET;
            cal_sel_reg <= cwfc_pkg::CAL_SEL_RESET;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            rdata_reg   <= 32'h0000_0000;
        end else begin
            ctrl_reg    <= ctrl_next;
            tx_mu_reg   <= tx_mu_next;
            cal_sel_reg <= cal_sel_next;
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
            rdata_reg   <= rdata_next;
        end
    end

    // ========================================================================
    // Transmit: calendar packing, multi-use insert, sequence numbering
    always_comb begin
        logic [7:0] idx;
        logic [7:0] mu_raw;
        idx           = 8'h00;
        tx_group_next = tx_group_reg;
        tx_seq_next   = tx_seq_reg;
        tx_sub_next   = tx_sub_reg;
        tx_vld_next   = tx_cw_req_in;
        tx_fld_next   = tx_fld_reg;
        mu_raw        = tx_resend_on ? tx_seq_reg : tx_mu_reg;
        if (tx_cw_req_in) begin
            tx_fld_next.restart = (tx_group_reg == 4'h0);
            for (int i = 0; i < cwfc_pkg::CAL_GROUP_W; i++) begin
                idx = {tx_group_reg, 4'(i)};
                tx_fld_next.fc[15 - i] = tx_flow_calendar_in[idx];
            end
            tx_group_next = (tx_group_reg >= cal_last) ? 4'h0 : tx_group_reg + 4'h1;
            tx_fld_next.mu = mu_raw & mu_mask(tx_channel_extension_sel);
            // One number covers mult bursts, then steps within the free bits
            if (tx_resend_on && tx_cw_burst_in) begin
                if (tx_sub_reg >= mult_last) begin
                    tx_sub_next = 5'h00;
                    tx_seq_next = (tx_seq_reg + 8'h01)
                                  & mu_mask(tx_channel_extension_sel);
                end else begin
                    tx_sub_next = tx_sub_reg + 5'h01;
                end
            end
        end
        // Leaving resend mode restarts numbering from zero
        if (!tx_resend_on) begin
            tx_seq_next = 8'h00;
            tx_sub_next = 5'h00;
        end
    end

    // Transmit registers
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_group_reg <= 4'h0;
            tx_seq_reg   <= 8'h00;
            tx_sub_reg   <= 5'h00;
            tx_vld_reg   <= 1'b0;
            tx_fld_reg   <= '0;
        end else begin
            tx_group_reg <= tx_group_next;
            tx_seq_reg   <= tx_seq_next;
            tx_sub_reg   <= tx_sub_next;
            tx_vld_reg   <= tx_vld_next;
            tx_fld_reg   <= tx_fld_next;
        end
    end

    // ========================================================================
    // Receive: multi-use extract and resend request
    always_comb begin
        logic take;
        take         = rx_cw_valid_in && (!rx_resend_on || rx_cw_burst_in);
        rx_mu_next   = rx_mu_reg;
        rx_upd_next  = 1'b0;
        oob_req_next = oob_req_reg;
        if (take) begin
            rx_mu_next  = rx_cw_fields_in.mu & mu_mask(rx_channel_extension_sel);
            rx_upd_next = 1'b1;
        end
        // A clean burst word marks the resend start; a new error wins
        if (rx_cw_valid_in && rx_cw_burst_in && !rx_crc24_error_in) begin
            oob_req_next = 1'b0;
        end
        if (rx_resend_on && rx_crc24_error_in) begin
            oob_req_next = 1'b1;
        end
        if (!rx_resend_on) begin
            oob_req_next = 1'b0;
        end
    end

    // Receive registers
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_mu_reg   <= 8'h00;
            rx_upd_reg  <= 1'b0;
            oob_req_reg <= 1'b0;
        end else begin
            rx_mu_reg   <= rx_mu_next;
            rx_upd_reg  <= rx_upd_next;
            oob_req_reg <= oob_req_next;
        end
    end

    // ========================================================================
    // Receive calendar store
    cwfc_rx_calendar u_rx_cal (
        .ref_clk_in     (ref_clk_in),
        .rst_n_in       (rst_n_in),
        .cw_valid_in    (rx_cw_valid_in),
        .cw_fields_in   (rx_cw_fields_in),
        .last_group_in  (cal_last),
        .group_sel_in   (cal_sel_reg),
        .calendar_out   (rx_flow_calendar_out),
        .group_word_out (rx_group_word),
        .locked_out     (rx_cal_locked)
    );

    // ========================================================================
    // Outputs from flip-flops, except the constant hreadyout_out and hresp_out
    assign hrdata_out                   = rdata_reg;
    assign hreadyout_out                = 1'b1;
    assign hresp_out                    = 1'b0;
    assign tx_cw_valid_out              = tx_vld_reg;
    assign tx_cw_fields_out             = tx_fld_reg;
    assign rx_multiuse_out              = rx_mu_reg;
    assign rx_multiuse_updated_out      = rx_upd_reg;
    assign oob_resend_req_out           = oob_req_reg;
    assign oob_resend_pos_out           = ctrl_reg[cwfc_pkg::CTRL_OOBPOS_LO +: 8];
    assign rx_packet_interleave_sel_out = ctrl_reg[cwfc_pkg::CTRL_INTERLEAVE];

endmodule

// >>> hdl/cwfc_pkg.sv
// Shared constants and types for the control word flow calendar block.
// Assumes one 40 MHz clock and an AHB-Lite register slave with 32-bit data.
package cwfc_pkg;

    // ========================================================================
    // Register map (byte addresses)
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_TX_MU    = 8'h04;
    localparam logic [7:0] ADDR_STATUS   = 8'h08;
    localparam logic [7:0] ADDR_CAL_SEL  = 8'h0c;
    localparam logic [7:0] ADDR_CAL_WORD = 8'h10;

    // ========================================================================
    // Control register fields
    localparam int CTRL_RX_RESEND  = 0;
    localparam int CTRL_TX_RESEND  = 1;
    localparam int CTRL_RX_EXT_LO  = 2;
    localparam int CTRL_TX_EXT_LO  = 4;
    localparam int CTRL_CALLEN_LO  = 6;
    localparam int CTRL_MULT_LO    = 10;
    localparam int CTRL_INTERLEAVE = 13;
    localparam int CTRL_OOBPOS_LO  = 14;
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
    localparam logic [7:0]  TX_MU_RESET  = 8'h00;
    localparam logic [3:0]  CAL_SEL_RESET = 4'h0;

    // ========================================================================
    // Status register fields
    localparam int STAT_RX_MU_LO  = 0;
    localparam int STAT_TX_SEQ_LO = 8;
    localparam int STAT_OOB_REQ   = 16;
    localparam int STAT_CAL_LOCK  = 17;

    // ========================================================================
    // Calendar and multiplier encodings
    localparam int          CAL_ENTRIES   = 256;
    localparam int          CAL_GROUP_W   = 16;
    localparam logic [3:0]  CALLEN_16     = 4'h0;
    localparam logic [3:0]  CALLEN_32     = 4'h1;
    localparam logic [3:0]  CALLEN_64     = 4'h3;
    localparam logic [3:0]  CALLEN_128    = 4'h7;
    localparam logic [3:0]  CALLEN_256    = 4'hf;
    localparam logic [2:0]  MULT_CODE_MAX = 3'h5;
    localparam logic [7:0]  MU_FULL_MASK  = 8'hff;

    // ========================================================================
    // Side-band fields of one control word
    typedef struct packed {
        logic        restart;   // Word bit 56
        logic [15:0] fc;        // Word bits 55:40, fc[15] is bit 55
        logic [7:0]  mu;        // Word bits 31:24, mu[0] is bit 24
    } cwfc_side_t;

    typedef enum logic [1:0] {
        CAL_HUNT  = 2'b01,
        CAL_TRACK = 2'b10
    } cwfc_cal_state_t;

endpackage

// >>> hdl/cwfc_rx_calendar.sv
// Receive flow calendar store: unpacks in-band flow bits into 256 entries.
// Assumes a fresh control word is flagged by a one-cycle valid strobe.
`timescale 1ns/1ps
module cwfc_rx_calendar (
    input  wire logic               ref_clk_in,
    input  wire logic               rst_n_in,
    input  wire logic               cw_valid_in,
    input  wire cwfc_pkg::cwfc_side_t cw_fields_in,
    input  wire logic [3:0]         last_group_in,
    input  wire logic [3:0]         group_sel_in,
    output logic [255:0]            calendar_out,
    output logic [15:0]             group_word_out,
    output logic                    locked_out
);

    // ========================================================================
    // State
    cwfc_pkg::cwfc_cal_state_t state_reg, state_next;
    logic [4:0]   group_reg, group_next;
    logic [255:0] cal_reg, cal_next;

    // Follow restart flags; a word past the calendar end drops back to hunt
    always_comb begin
        logic [7:0] idx;
        logic [4:0] wr_group;
        logic       do_write;
        idx        = 8'h00;
        state_next = state_reg;
        group_next = group_reg;
        cal_next   = cal_reg;
        wr_group   = group_reg;
        do_write   = 1'b0;
        if (cw_valid_in) begin
            case (state_reg)
                cwfc_pkg::CAL_HUNT: begin
                    if (cw_fields_in.restart) begin
                        wr_group   = 5'h00;
                        do_write   = 1'b1;
                        state_next = cwfc_pkg::CAL_TRACK;
                    end
                end
                cwfc_pkg::CAL_TRACK: begin
                    if (cw_fields_in.restart) begin
                        wr_group = 5'h00;
                        do_write = 1'b1;
                    end else if (group_reg > {1'b0, last_group_in}) begin
                        state_next = cwfc_pkg::CAL_HUNT;
                    end else begin
                        do_write = 1'b1;
                    end
                end
                default: begin
                    state_next = cwfc_pkg::CAL_HUNT;
                end
            endcase
        end
        if (do_write) begin
            for (int i = 0; i < cwfc_pkg::CAL_GROUP_W; i++) begin
                idx = {wr_group[3:0], 4'(i)};
                cal_next[idx] = cw_fields_in.fc[15 - i];
            end
            group_next = wr_group + 5'h01;
        end
    end

    // Untouched entries keep their last value
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= cwfc_pkg::CAL_HUNT;
            group_reg <= 5'h00;
            cal_reg   <= '0;
        end else begin
            state_reg <= state_next;
            group_reg <= group_next;
            cal_reg   <= cal_next;
        end
    end

    assign calendar_out   = cal_reg;
    assign group_word_out = cal_reg[{group_sel_in, 4'h0} +: 16];
    assign locked_out     = (state_reg == cwfc_pkg::CAL_TRACK);

endmodule

// >>> dv/cwfc_sva.sv
// Checker bound to cwfc_top; one clock, async active-low reset.
`timescale 1ns/1ps
module cwfc_sva (
    input wire logic                 ref_clk_in,
    input wire logic                 rst_n_in,
    input wire logic                 hreadyout_out,
    input wire logic                 hresp_out,
    input wire logic                 tx_cw_req_in,
    input wire logic                 tx_cw_valid_out,
    input wire cwfc_pkg::cwfc_side_t tx_cw_fields_out,
    input wire logic                 rx_cw_valid_in,
    input wire logic                 rx_cw_burst_in,
    input wire cwfc_pkg::cwfc_side_t rx_cw_fields_in,
    input wire logic [7:0]           rx_multiuse_out,
    input wire logic                 rx_multiuse_updated_out,
    input wire logic [255:0]         rx_flow_calendar_out
);
    // Entry 0 rides the top bit
    function automatic logic [15:0] flip(input logic [15:0] v);
        for (int i = 0; i < 16; i++) flip[i] = v[15-i];
    endfunction

    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    // ========
    // Lone burst word; one-cycle pulse
    sequence s_rx_one;
        rx_cw_valid_in && rx_cw_burst_in ##1 !rx_cw_valid_in;
    endsequence
    sequence s_pulse;
        rx_multiuse_updated_out ##1 !rx_multiuse_updated_out;
    endsequence

    // ========
    // Properties
    AST_MU_PULSE: assert property (s_rx_one |-> s_pulse)
        else $error("update pulse not one cycle");
    AST_MU_CAUSE: assert property (rx_multiuse_updated_out |-> $past(rx_cw_valid_in))
        else $error("stray update pulse");
    AST_MU_HOLD: assert property (!rx_multiuse_updated_out |-> $stable(rx_multiuse_out))
        else $error("multi-use moved");
    AST_RX_GROUP0: assert property (rx_cw_valid_in && rx_cw_fields_in.restart |=>
        rx_flow_calendar_out[15:0] == flip($past(rx_cw_fields_in.fc)))
        else $error("group 0 wrong");
    AST_CAL_HOLD: assert property (!rx_cw_valid_in |=> $stable(rx_flow_calendar_out))
        else $error("calendar moved");
    AST_TX_VALID: assert property (tx_cw_req_in |=> tx_cw_valid_out)
        else $error("no transmit word");
    AST_TX_IDLE: assert property (!tx_cw_req_in |=> !tx_cw_valid_out)
        else $error("stray transmit word");
    AST_TX_HOLD: assert property (!tx_cw_req_in |=> $stable(tx_cw_fields_out))
        else $error("transmit fields moved");
    AST_BUS_OKAY: assert property (hreadyout_out && !hresp_out)
        else $error("bus not okay");
endmodule

// >>> dv/cwfc_partner.sv
// Link partner model: feeds received control words.
// Driven through its send task.
`timescale 1ns/1ps
module cwfc_partner (
    input  wire logic           ref_clk_in,
    output logic                rx_cw_valid_out,
    output logic                rx_cw_burst_out,
    output logic                rx_crc24_error_out,
    output cwfc_pkg::cwfc_side_t rx_cw_fields_out
);
    // Idle at time zero
    initial begin
        rx_cw_valid_out = 1'b0;
        rx_cw_burst_out = 1'b0;
        rx_crc24_error_out = 1'b0;
        rx_cw_fields_out = '0;
    end

    // One word, then the inverse so stale values fail
    task automatic send(input logic rs, input logic [15:0] fc, input logic [7:0] mu,
                        input logic b, input logic e);
        @(posedge ref_clk_in);
        rx_cw_valid_out <= 1'b1;
        rx_cw_burst_out <= b;
        rx_crc24_error_out <= e;
        rx_cw_fields_out <= {rs, fc, mu};
        @(posedge ref_clk_in);
        rx_cw_valid_out <= 1'b0;
        rx_cw_burst_out <= ~b;
        rx_crc24_error_out <= 1'b0;
        rx_cw_fields_out <= ~{rs, fc, mu};
        #1;
    endtask
endmodule

// >>> dv/cwfc_top_test.sv
// Bench for cwfc_top and its link partner.
// AHB master tasks, 40 MHz clock, watchdog.
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
    $display("MISMATCH %0t got %0h exp %0h", $time, a, b); end end
module cwfc_top_test;
    logic ref_clk_in, rst_n_in, hsel_in, hwrite_in, hreadyout_out, hresp_out;
    logic [7:0] haddr_in;
    logic [1:0] htrans_in;
    logic [2:0] hsize_in;
    logic [31:0] hwdata_in, hrdata_out;
    logic tx_cw_req_in, tx_cw_burst_in, tx_cw_valid_out;
    logic [255:0] tx_flow_calendar_in, rx_flow_calendar_out;
    cwfc_pkg::cwfc_side_t tx_cw_fields_out, rx_cw_fields_in;
    logic rx_cw_valid_in, rx_cw_burst_in, rx_crc24_error_in, rx_multiuse_updated_out;
    logic [7:0] rx_multiuse_out, oob_resend_pos_out;
    logic oob_resend_req_out, rx_packet_interleave_sel_out;
    int errors = 0;
    int tests_run = 0;
    logic [3:0] codes[5] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hf};

    cwfc_top uut (.ref_clk_in, .rst_n_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
        .hsize_in, .hwdata_in, .hready_in(hreadyout_out), .hrdata_out, .hreadyout_out,
        .hresp_out, .tx_cw_req_in, .tx_cw_burst_in, .tx_flow_calendar_in, .tx_cw_valid_out,
        .tx_cw_fields_out, .rx_cw_valid_in, .rx_cw_burst_in, .rx_crc24_error_in,
        .rx_cw_fields_in, .rx_multiuse_out, .rx_multiuse_updated_out, .rx_flow_calendar_out,
        .oob_resend_req_out, .oob_resend_pos_out, .rx_packet_interleave_sel_out);
    cwfc_partner p (.ref_clk_in, .rx_cw_valid_out(rx_cw_valid_in),
        .rx_cw_burst_out(rx_cw_burst_in), .rx_crc24_error_out(rx_crc24_error_in),
        .rx_cw_fields_out(rx_cw_fields_in));

    // ========
    // Clock, reset and bus helpers
    initial begin
        ref_clk_in = 1'b0;
        forever #12.5 ref_clk_in = ~ref_clk_in;
    end
    function automatic logic [15:0] rev16(input logic [15:0] v);
        for (int i = 0; i < 16; i++) rev16[i] = v[15-i];
    endfunction
    task automatic reset();
        rst_n_in <= 1'b0;
        repeat (8) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
    endtask
    // Single word transfer; waits on hready
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge ref_clk_in);
        hsel_in <= 1'b1; htrans_in <= 2'h2; haddr_in <= a; hwrite_in <= w;
        @(posedge ref_clk_in);
        while (hreadyout_out !== 1'b1) @(posedge ref_clk_in);
        hsel_in <= 1'b0; htrans_in <= 2'h0; hwdata_in <= d;
        @(posedge ref_clk_in);
        while (hreadyout_out !== 1'b1) @(posedge ref_clk_in);
        r = hrdata_out;
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    // One transmit request
    task automatic txw(input logic b);
        @(posedge ref_clk_in);
        tx_cw_req_in <= 1'b1; tx_cw_burst_in <= b;
        @(posedge ref_clk_in);
        tx_cw_req_in <= 1'b0; tx_cw_burst_in <= ~b;
        #1;
        `CHK(tx_cw_valid_out, 1'b1)
    endtask

    // ========================================================
    // Scenarios
    task automatic t_regs();
        logic [31:0] r;
        bus(1'b0, cwfc_pkg::ADDR_CTRL, 32'h0, r);
        `CHK(r, cwfc_pkg::CTRL_RESET)
        wr(8'h24, 32'hffff_ffff);
        bus(1'b0, 8'h24, 32'h0, r);
        `CHK(r, 32'h0)
        wr(cwfc_pkg::ADDR_TX_MU, 32'ha5);
        bus(1'b0, cwfc_pkg::ADDR_TX_MU, 32'h0, r);
        `CHK(r, 32'ha5)
    endtask
    // Length codes with one wrap, then multi-use masks
    task automatic t_tx();
        int n, g;
        foreach (codes[c]) begin
            reset();
            wr(cwfc_pkg::ADDR_CTRL, 32'(codes[c]) << 6);
            n = int'(codes[c]) + 1;
            for (int k = 0; k <= n; k++) begin
                txw(1'b0);
                g = k % n;
                `CHK(tx_cw_fields_out.restart, g == 0)
                `CHK(tx_cw_fields_out.fc, rev16(tx_flow_calendar_in[g*16 +: 16]))
            end
        end
        wr(cwfc_pkg::ADDR_TX_MU, 32'hff);
        for (int e = 0; e < 4; e++) begin
            wr(cwfc_pkg::ADDR_CTRL, 32'h3c0 | (e << 4));
            txw(1'b0);
            `CHK(tx_cw_fields_out.mu, 8'hff >> e)
        end
    endtask
    // Receive masks, unpack, hold and hunt
    task automatic t_rx();
        reset();
        for (int e = 0; e < 4; e++) begin
            wr(cwfc_pkg::ADDR_CTRL, 32'h40 | (e << 2));
            p.send(1'b1, 16'hc35a, 8'hff, 1'b0, 1'b0);
            `CHK(rx_multiuse_out, 8'hff >> e)
            `CHK(rx_multiuse_updated_out, 1'b1)
        end
        wr(cwfc_pkg::ADDR_CTRL, 32'h40);
        p.send(1'b0, 16'h0ff1, 8'h5a, 1'b0, 1'b0);
        `CHK(rx_multiuse_out, 8'h5a)
        `CHK(rx_flow_calendar_out[31:0], {rev16(16'h0ff1), rev16(16'hc35a)})
        p.send(1'b0, 16'hbeef, 8'h5a, 1'b0, 1'b0);
        p.send(1'b1, 16'h1234, 8'h5a, 1'b0, 1'b0);
        `CHK(rx_flow_calendar_out[47:0], {16'h0, rev16(16'h0ff1), rev16(16'h1234)})
    endtask
    // Resend capture, request, sequence
    task automatic t_rs();
        int m;
        reset();
        wr(cwfc_pkg::ADDR_CTRL, 32'h1 | (32'h2b << 14));
        `CHK(oob_resend_pos_out, 8'h2b)
        `CHK(rx_packet_interleave_sel_out, 1'b0)
        p.send(1'b1, 16'h0, 8'h22, 1'b1, 1'b0);
        p.send(1'b1, 16'h0, 8'h33, 1'b0, 1'b0);
        `CHK(rx_multiuse_out, 8'h22)
        p.send(1'b1, 16'h0, 8'h44, 1'b1, 1'b1);
        `CHK(oob_resend_req_out, 1'b1)
        p.send(1'b1, 16'h0, 8'h45, 1'b1, 1'b0);
        `CHK(oob_resend_req_out, 1'b0)
        wr(cwfc_pkg::ADDR_TX_MU, 32'hff);
        for (int c = 0; c < 6; c++) begin
            m = 1 << c;
            wr(cwfc_pkg::ADDR_CTRL, 32'h0);
            wr(cwfc_pkg::ADDR_CTRL, 32'h2 | (c << 10));
            for (int k = 0; k <= 2 * m; k++) begin
                txw(1'b1);
                `CHK(tx_cw_fields_out.mu, 8'(k / m))
            end
            txw(1'b0);
            `CHK(tx_cw_fields_out.mu, 8'((2 * m + 1) / m))
        end
    endtask

    // ========
    // Verdict and main sequence
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #(25ns * 40000);
        errors++;
        stop_test();
    end
    initial begin
        rst_n_in = 1'b0; hsel_in = 1'b0; hwrite_in = 1'b0; haddr_in = 8'h0;
        htrans_in = 2'h0; hsize_in = 3'h2; hwdata_in = 32'h0;
        tx_cw_req_in = 1'b0; tx_cw_burst_in = 1'b0;
        for (int i = 0; i < 16; i++) tx_flow_calendar_in[i*16 +: 16] = {4'(i), 8'h81, ~4'(i)};
        reset();
        t_regs();
        t_tx();
        t_rx();
        t_rs();
        stop_test();
    end
endmodule

bind cwfc_top cwfc_sva chk (.ref_clk_in, .rst_n_in, .hreadyout_out, .hresp_out,
    .tx_cw_req_in, .tx_cw_valid_out, .tx_cw_fields_out, .rx_cw_valid_in, .rx_cw_burst_in,
    .rx_cw_fields_in, .rx_multiuse_out, .rx_multiuse_updated_out, .rx_flow_calendar_out);
